// file: logic/aacd_regs.v
/*
 Configuration and DC diagnostic register bank of a one-channel digital
 input amplifier, with a small DC diagnostic sequencer.
 Assumes a byte-wide register port synchronous to clock (wr_en/rd_en with
 address), frame_strobe from the audio port, and analog measurement
 results presented as levels while diag_measure_done pulses.
*/
// What this block does
// R01: Rate field code 00 44.1 kHz, 01 48 kHz, 10 96 kHz, 11 reserved.
// R02: Slot codes 000 and 001 pick slot or channel one and two.
// R03: Slot codes 010, 011 pick slots three, four; 100-111 only in eight-slot.
// R04: Format codes 000-011 give right-justified 24, 20, 18, 16 bits.
// R05: Format 100 serial audio, 101 left-justified, 110 DSP; 111 reserved.
// R06: Audio port configuration at 0x03 resets to 0x04.
// R07: State request 00 play, 01 high-impedance, 10 mute, 11 diagnostic.
// R08: State request register at 0x04 resets to 0x55, high-impedance.
// R09: Level 0.5 dB per code; below 0x07 mutes the output.
// R10: Level register at 0x05 resets to 0xcf, unity gain.
// R11: Writing one to cancel bit aborts a running diagnostic.
// R12: Host writes the cancel bit back to zero before reuse.
// R13: Ramp double bit doubles the diagnostic ramp time.
// R14: Settle double bit doubles the diagnostic settling time.
// R15: Line-output check bit enables line-output detection in diagnostics.
// R16: Auto check skip clear runs diagnostics leaving high-impedance or after fault.
// R17: Upper four bits of second control select short threshold, reset 0001.
// R18: Result bit 7 ground short, bit 6 supply short.
// R19: Result bit 5 open load, bit 4 shorted load; low bits zero.
// R20: Line-out report bit 3 shows a line-level load found.
// R21: Level ramps one step per 1, 2, 4 or 8 frame strobes.
// R22: State report shows actual state, same codes, resets high-impedance.
// R23: Reserved writable bits store and read back, no effect.
// R24: Result flags clear at run start and update at run end.
`timescale 1ns/1ps
`include "aacd_defines.vh"

module aacd_regs (
    // Clock and reset.
    input wire clock,
    input wire reset_n,
    // Register port.
    input wire wr_en,
    input wire rd_en,
    input wire [7:0] address,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data,
    output reg rd_valid,
    // Audio port timing and channel events.
    input wire frame_strobe,
    input wire channel_fault,
    // Analog measurement results.
    input wire diag_measure_done,
    input wire gnd_short_flag,
    input wire supply_short_flag,
    input wire open_flag,
    input wire load_short_flag,
    input wire lineout_found_flag,
    // Decoded configuration toward the datapath.
    output wire [1:0] rate_select,
    output wire [2:0] audio_port_slot,
    output wire [2:0] audio_port_format,
    output wire config_invalid,
    output wire [3:0] short_limit_sel,
    output wire lineout_check_on,
    output wire [7:0] output_level,
    output wire output_muted,
    output wire [1:0] output_state_seen,
    output wire diag_measure_start
);

    // ==================================================================
    // Sequencer states, one-hot.
    localparam S_IDLE = 4'b0001;
    localparam S_RAMP = 4'b0010;
    localparam S_SETTLE = 4'b0100;
    localparam S_MEASURE = 4'b1000;

    reg [7:0] audio_port_config;
    reg [7:0] output_state_request;
    reg [7:0] output_level_reg;
    reg [7:0] diag_control_a;
    reg [7:0] diag_control_b;
    reg [7:0] level_rate;
    reg [3:0] diag_result_a;
    reg line_out_result;
    reg [1:0] state_seen;
    reg [3:0] diag_state;
    reg [3:0] next_diag_state;
    reg [`AACD_CNT_W-1:0] phase_count;
    reg [`AACD_CNT_W-1:0] next_phase_count;
    reg fault_pending;
    reg [1:0] next_state_seen;
    reg [1:0] after_diag;
    wire write_cancel;
    wire diag_cancel;
    wire ramp_double;
    wire settle_double;
    wire auto_check_skip;
    wire [1:0] output_state_req;
    wire leaving_hiz;
    wire auto_start;
    wire host_start;
    wire run_start;
    wire [`AACD_CNT_W-1:0] ramp_len;
    wire [`AACD_CNT_W-1:0] settle_len;
    wire [7:0] applied_level;

    // Doubles a phase length when its double bit is set.
    function [`AACD_CNT_W-1:0] phase_len;
        input [`AACD_CNT_W-1:0] base;
        input dbl;
        begin
            phase_len = dbl ? {base[`AACD_CNT_W-2:0], 1'b0} : base;
        end
    endfunction

    // ==================================================================
    // Field decode.
    // R01 rate field
    assign rate_select = audio_port_config[`AACD_RATE_HI:`AACD_RATE_LO];
    // R02 slot field
    assign audio_port_slot = audio_port_config[`AACD_SLOT_HI:`AACD_SLOT_LO];
    // R04 format field
    assign audio_port_format = audio_port_config[`AACD_FMT_HI:`AACD_FMT_LO];
    // R05 reserved codes flagged
    // R03 eight-slot codes
    // Slots above four are only meaningful in eight-slot framing; the
    // datapath checks that against its detected frame length.
    assign config_invalid = (rate_select == `AACD_RATE_RSVD) ||
                            (audio_port_format == `AACD_FMT_RSVD);
    // R17 short threshold
    assign short_limit_sel = diag_control_b[`AACD_SHORT_HI:`AACD_SHORT_LO];
    // R15 line-output enable
    assign lineout_check_on = diag_control_a[`AACD_LINEOUT_BIT];
    assign diag_cancel = diag_control_a[`AACD_CANCEL_BIT];
    assign ramp_double = diag_control_a[`AACD_RAMP2_BIT];
    assign settle_double = diag_control_a[`AACD_SETTLE2_BIT];
    assign auto_check_skip = diag_control_a[`AACD_SKIP_BIT];
    // R07 state request field
    assign output_state_req = output_state_request[`AACD_STATE_HI:`AACD_STATE_LO];
    // R22 state report
    assign output_state_seen = state_seen;
    assign output_level = applied_level;
    // R09 mute below floor
    assign output_muted = (applied_level < `AACD_LEVEL_MIN) ||
                          (state_seen != `AACD_ST_PLAY);
    assign diag_measure_start = (diag_state == S_MEASURE);

    // ==================================================================
    // Level ramp toward the programmed level.
    aacd_level_ramp u_ramp (
        .clock(clock),
        .reset_n(reset_n),
        .frame_strobe(frame_strobe),
        .rate_code(level_rate[`AACD_LRATE_HI:`AACD_LRATE_LO]),
        .target_level(output_level_reg),
        .applied_level(applied_level)
    );

    // ==================================================================
    // Register writes. Reserved bits are plain storage.
    assign write_cancel = wr_en && (address == `AACD_OFF_DIAG_A) &&
                          wr_data[`AACD_CANCEL_BIT];

    // R06 R08 R10 resets; R23 reserved storage
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            audio_port_config <= `AACD_RST_PORT_CFG;
            output_state_request <= `AACD_RST_STATE_REQ;
            output_level_reg <= `AACD_RST_LEVEL;
            diag_control_a <= `AACD_RST_DIAG_A;
            diag_control_b <= `AACD_RST_DIAG_B;
            level_rate <= `AACD_RST_LEVEL_RATE;
        end else if (wr_en) begin
            case (address)
                `AACD_OFF_PORT_CFG: audio_port_config <= wr_data;
                `AACD_OFF_STATE_REQ: output_state_request <= wr_data;
                `AACD_OFF_LEVEL: output_level_reg <= wr_data;
                `AACD_OFF_DIAG_A: diag_control_a <= wr_data;
                `AACD_OFF_DIAG_B: diag_control_b <= wr_data;
                `AACD_OFF_LEVEL_RATE: level_rate <= wr_data;
                default: ;
            endcase
        end
    end

    // ==================================================================
    // Register reads, answered the cycle after rd_en.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
            if (rd_en) begin
                case (address)
                    `AACD_OFF_PORT_CFG: rd_data <= audio_port_config;
                    `AACD_OFF_STATE_REQ: rd_data <= output_state_request;
                    `AACD_OFF_LEVEL: rd_data <= output_level_reg;
                    `AACD_OFF_DIAG_A: rd_data <= diag_control_a;
                    `AACD_OFF_DIAG_B: rd_data <= diag_control_b;
                    `AACD_OFF_LEVEL_RATE: rd_data <= level_rate;
                    // R18 R19 result layout
                    `AACD_OFF_RESULT: rd_data <= {diag_result_a, 4'h0};
                    // R20 line-out bit
                    `AACD_OFF_LINEOUT: rd_data <= {4'h0, line_out_result, 3'h0};
                    `AACD_OFF_STATE_SEEN: rd_data <= {state_seen, 6'h00};
                    default: rd_data <= 8'h00;
                endcase
            end
        end
    end

    // ==================================================================
    // Diagnostic run triggers.
    // R16 automatic run
    assign leaving_hiz = (state_seen == `AACD_ST_HIZ) && (output_state_req != `AACD_ST_HIZ);
    assign auto_start = !auto_check_skip && (leaving_hiz || fault_pending);
    assign host_start = (output_state_req == `AACD_ST_DIAG) && (state_seen != `AACD_ST_DIAG);
    // R12 cancel held blocks runs
    assign run_start = (diag_state == S_IDLE) && !diag_cancel && !write_cancel &&
                       (auto_start || host_start);
    // R13 R14 phase lengths
    assign ramp_len = phase_len(`AACD_RAMP_CYC, ramp_double);
    assign settle_len = phase_len(`AACD_SETTLE_CYC, settle_double);

    // A fault seen while idle is held until the run it triggers begins.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n)
            fault_pending <= 1'b0;
        else if (channel_fault)
            fault_pending <= 1'b1;
        else if (run_start || auto_check_skip)
            fault_pending <= 1'b0;
    end

    // Sequencer next-state logic.
    always @* begin
        next_diag_state = diag_state;
        next_phase_count = phase_count;
        next_state_seen = state_seen;
        case (diag_state)
            S_IDLE: begin
                if (run_start) begin
                    next_diag_state = S_RAMP;
                    next_phase_count = ramp_len;
                    next_state_seen = `AACD_ST_DIAG;
                end else if (output_state_req != `AACD_ST_DIAG) begin
                    next_state_seen = output_state_req;
                end
            end
            S_RAMP: begin
                if (phase_count == {`AACD_CNT_W{1'b0}}) begin
                    next_diag_state = S_SETTLE;
                    next_phase_count = settle_len;
                end else begin
                    next_phase_count = phase_count - {{(`AACD_CNT_W-1){1'b0}}, 1'b1};
                end
            end
            S_SETTLE: begin
                if (phase_count == {`AACD_CNT_W{1'b0}})
                    next_diag_state = S_MEASURE;
                else
                    next_phase_count = phase_count - {{(`AACD_CNT_W-1){1'b0}}, 1'b1};
            end
            S_MEASURE: begin
                if (diag_measure_done) begin
                    next_diag_state = S_IDLE;
                    next_state_seen = after_diag;
                end
            end
            default: next_diag_state = S_IDLE;
        endcase
        // R11 abort
        if (write_cancel && (diag_state != S_IDLE)) begin
            next_diag_state = S_IDLE;
            next_state_seen = after_diag;
        end
    end

    // After a run the channel goes to the requested state, or to
    // high-impedance when the host itself asked for the run.
    always @* begin
        if (output_state_req == `AACD_ST_DIAG)
            after_diag = `AACD_ST_HIZ;
        else
            after_diag = output_state_req;
    end

    // Sequencer registers.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            diag_state <= S_IDLE;
            phase_count <= {`AACD_CNT_W{1'b0}};
            state_seen <= `AACD_ST_HIZ;
        end else begin
            diag_state <= next_diag_state;
            phase_count <= next_phase_count;
            state_seen <= next_state_seen;
        end
    end

    // R24 result clear and update
    // An aborted run leaves the flags cleared, as nothing was measured.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            diag_result_a <= 4'h0;
            line_out_result <= 1'b0;
        end else if (run_start) begin
            diag_result_a <= 4'h0;
            line_out_result <= 1'b0;
        end else if ((diag_state == S_MEASURE) && diag_measure_done && !write_cancel) begin
            diag_result_a <= {gnd_short_flag, supply_short_flag, open_flag, load_short_flag};
            line_out_result <= lineout_check_on && lineout_found_flag;
        end
    end

endmodule // aacd_regs

// file: logic/aacd_defines.vh
/*
 Constants for the amplifier configuration and diagnostic register bank:
 register offsets, reset values, field positions, codes and timing counts.
 Assumes it is included by bare name from the design files of this block.
*/
`ifndef AACD_DEFINES_VH
`define AACD_DEFINES_VH

// ==================================================================
// Register offsets.
`define AACD_OFF_PORT_CFG 8'h03
`define AACD_OFF_STATE_REQ 8'h04
`define AACD_OFF_LEVEL 8'h05
`define AACD_OFF_DIAG_A 8'h09
`define AACD_OFF_DIAG_B 8'h0a
`define AACD_OFF_RESULT 8'h0c
`define AACD_OFF_LINEOUT 8'h0e
`define AACD_OFF_STATE_SEEN 8'h0f
`define AACD_OFF_LEVEL_RATE 8'h01

// ==================================================================
// Reset values.
`define AACD_RST_PORT_CFG 8'h04
`define AACD_RST_STATE_REQ 8'h55
`define AACD_RST_LEVEL 8'hcf
`define AACD_RST_DIAG_A 8'h00
`define AACD_RST_DIAG_B 8'h11
`define AACD_RST_LEVEL_RATE 8'h00

// ==================================================================
// Field positions.
`define AACD_RATE_HI 7
`define AACD_RATE_LO 6
`define AACD_SLOT_HI 5
`define AACD_SLOT_LO 3
`define AACD_FMT_HI 2
`define AACD_FMT_LO 0
`define AACD_STATE_HI 7
`define AACD_STATE_LO 6
`define AACD_CANCEL_BIT 7
`define AACD_RAMP2_BIT 6
`define AACD_SETTLE2_BIT 5
`define AACD_LINEOUT_BIT 1
`define AACD_SKIP_BIT 0
`define AACD_SHORT_HI 7
`define AACD_SHORT_LO 4
`define AACD_GND_BIT 7
`define AACD_SUPPLY_BIT 6
`define AACD_OPEN_BIT 5
`define AACD_LSHORT_BIT 4
`define AACD_LOFOUND_BIT 3
`define AACD_LRATE_HI 3
`define AACD_LRATE_LO 2

// ==================================================================
// Codes.
`define AACD_ST_PLAY 2'h0
`define AACD_ST_HIZ 2'h1
`define AACD_ST_MUTE 2'h2
`define AACD_ST_DIAG 2'h3
`define AACD_LEVEL_MIN 8'h07
`define AACD_RATE_RSVD 2'h3
`define AACD_FMT_RSVD 3'h7
`define AACD_SLOT_TDM4_MAX 3'h3

// ==================================================================
// Diagnostic phase lengths in microseconds and derived 50 MHz cycles.
`define AACD_CLK_MHZ 50
`define AACD_RAMP_US 20
`define AACD_SETTLE_US 10
// Sized to the phase counter, so loading them drops no bits.
`define AACD_RAMP_CYC 12'h3e8
`define AACD_SETTLE_CYC 12'h1f4
`define AACD_CNT_W 12

`endif

// file: logic/aacd_level_ramp.v
/*
 Output level ramp: walks the applied level one 0.5 dB code toward the
 programmed level every 1, 2, 4 or 8 frame strobes.
 Assumes frame_strobe is a one-cycle pulse synchronous to clock.
*/
`timescale 1ns/1ps
`include "aacd_defines.vh"

module aacd_level_ramp (
    // Clock and reset.
    input wire clock,
    input wire reset_n,
    // Control.
    input wire frame_strobe,
    input wire [1:0] rate_code,
    input wire [7:0] target_level,
    // Result.
    output reg [7:0] applied_level
);

    reg [2:0] strobe_count;
    wire [2:0] strobe_limit;

    // ==================================================================
    // Frame strobe divider.
    // Rate code n means one step per 2**n strobes.
    assign strobe_limit = (3'h1 << rate_code) - 3'h1;

    // R21 step per strobes
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            strobe_count <= 3'h0;
            applied_level <= `AACD_RST_LEVEL;
        end else if (frame_strobe) begin
            if (strobe_count >= strobe_limit) begin
                strobe_count <= 3'h0;
                if (applied_level < target_level)
                    applied_level <= applied_level + 8'h01;
                else if (applied_level > target_level)
                    applied_level <= applied_level - 8'h01;
            end else begin
                strobe_count <= strobe_count + 3'h1;
            end
        end
    end

endmodule // aacd_level_ramp

// file: tb/aacd_checker.sv
/*
 Port assertions for the amplifier configuration and diagnostic register bank.
 Assumes it is bound to aacd_regs, with one clock and an asynchronous low reset.
*/
`timescale 1ns/1ps

module aacd_checker (
    // Clock, reset and register port.
    input wire clock,
    input wire reset_n,
    input wire wr_en,
    input wire [7:0] address,
    input wire [7:0] wr_data,
    // Decoded configuration and channel outputs.
    input wire [1:0] rate_select,
    input wire [2:0] audio_port_slot,
    input wire [2:0] audio_port_format,
    input wire config_invalid,
    input wire [3:0] short_limit_sel,
    input wire lineout_check_on,
    input wire [7:0] output_level,
    input wire output_muted,
    input wire [1:0] output_state_seen,
    input wire diag_measure_start
);
    // ==================================================================
    // Checks share the one clock; reset silences them all.
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    a_port_cfg_write: assert property (wr_en && address == 8'h03 |=>
        {rate_select, audio_port_slot, audio_port_format} == $past(wr_data))
        else $error("port configuration not taken from write");
    a_short_limit_write: assert property (wr_en && address == 8'h0a |=>
        short_limit_sel == $past(wr_data[7:4])) else $error("short limit not written");
    a_lineout_write: assert property (wr_en && address == 8'h09 |=>
        lineout_check_on == $past(wr_data[1])) else $error("line-out enable not written");
    a_config_invalid_flag: assert property (config_invalid ==
        (rate_select == 2'h3 || audio_port_format == 3'h7)) else $error("bad invalid flag");
    a_low_level_mute: assert property (output_level < 8'h07 |-> output_muted)
        else $error("level below minimum not muted");
    a_level_one_step: assert property (!$stable(output_level) |->
        (output_level - $past(output_level) == 8'h01) ||
        ($past(output_level) - output_level == 8'h01)) else $error("level jumped");
    a_measure_in_diag: assert property (diag_measure_start |->
        output_state_seen == 2'h3) else $error("measuring outside diagnostic state");
    a_ramp_before_measure: assert property ($rose(output_state_seen == 2'h3) |->
        !diag_measure_start [*8]) else $error("measurement began without ramp");

    // Main scenarios reached.
    c_measure: cover property (diag_measure_start);
    c_diag_end: cover property ($fell(output_state_seen == 2'h3));
    c_play_mute: cover property (output_muted && output_state_seen == 2'h0);
endmodule // aacd_checker

bind aacd_regs aacd_checker aacd_checker_i (.clock(clock), .reset_n(reset_n),
    .wr_en(wr_en), .address(address), .wr_data(wr_data), .rate_select(rate_select),
    .audio_port_slot(audio_port_slot), .audio_port_format(audio_port_format),
    .config_invalid(config_invalid), .short_limit_sel(short_limit_sel),
    .lineout_check_on(lineout_check_on), .output_level(output_level),
    .output_muted(output_muted), .output_state_seen(output_state_seen),
    .diag_measure_start(diag_measure_start));

// file: tb/aacd_meas_model.sv
/*
 Behavioural model of the analog load measurement behind the bank.
 Assumes diag_measure_start is a level that drops once done is seen.
*/
`timescale 1ns/1ps

module aacd_meas_model (
    // Clock and reset.
    input wire clock,
    input wire reset_n,
    // Control from the bench and the bank.
    input wire diag_measure_start,
    input wire [4:0] flags_set,
    input wire [7:0] reply_delay,
    // Measurement answer.
    output reg diag_measure_done,
    output reg [4:0] flags_out
);
    reg [7:0] count;

    // ==================================================================
    // Flags are only valid with done; otherwise they show the inverse so
    // that a bank sampling at the wrong moment picks up wrong values.
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            count <= 8'h00;
            diag_measure_done <= 1'b0;
            flags_out <= 5'h00;
        end else begin
            diag_measure_done <= diag_measure_start && count == reply_delay;
            flags_out <= (diag_measure_start && count == reply_delay) ? flags_set : ~flags_set;
            if (!diag_measure_start) count <= 8'h00;
            else if (count != 8'hff) count <= count + 8'h01;
        end
    end
endmodule // aacd_meas_model

// file: tb/aacd_regs_tb.sv
/*
 Self-checking bench for the register bank with a measurement model.
 Assumes inputs change on the falling edge and the bank samples on the rising.
*/
`timescale 1ns/1ps

module aacd_regs_tb;
    reg clock = 1'b0;
    reg reset_n = 1'b0;
    reg wr_en = 1'b0;
    reg rd_en = 1'b0;
    reg [7:0] address = 8'h00;
    reg [7:0] wr_data = 8'h00;
    reg frame_strobe = 1'b0;
    reg channel_fault = 1'b0;
    reg [4:0] flags_set = 5'h00;
    reg [7:0] reply_delay = 8'h03;
    wire [7:0] rd_data, output_level;
    wire [4:0] mf;
    wire [3:0] short_limit_sel;
    wire [2:0] slot, fmt;
    wire [1:0] rate, state;
    wire rd_valid, done, invalid, lineout_check_on, output_muted, measure;
    integer miscompares = 0;
    integer samples_checked = 0;
    integer i;
    reg [7:0] v;

    always #10 clock = ~clock;

    aacd_regs aacd_regs_i (.clock(clock), .reset_n(reset_n), .wr_en(wr_en), .rd_en(rd_en),
        .address(address), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .frame_strobe(frame_strobe), .channel_fault(channel_fault),
        .diag_measure_done(done), .gnd_short_flag(mf[4]), .supply_short_flag(mf[3]),
        .open_flag(mf[2]), .load_short_flag(mf[1]), .lineout_found_flag(mf[0]),
        .rate_select(rate), .audio_port_slot(slot), .audio_port_format(fmt),
        .config_invalid(invalid), .short_limit_sel(short_limit_sel),
        .lineout_check_on(lineout_check_on), .output_level(output_level),
        .output_muted(output_muted), .output_state_seen(state), .diag_measure_start(measure));

    aacd_meas_model aacd_meas_model_i (.clock(clock), .reset_n(reset_n),
        .diag_measure_start(measure), .flags_set(flags_set), .reply_delay(reply_delay),
        .diag_measure_done(done), .flags_out(mf));

    // ==================================================================
    // Comparison, verdict and register port tasks.
    task check(input string name, input [7:0] seen, input [7:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch %0s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    task end_of_test;
        begin
            $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
            if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask

    task wr(input [7:0] a, input [7:0] d);
        begin
            wr_en = 1'b1; address = a; wr_data = d;
            @(negedge clock) wr_en = 1'b0;
            @(negedge clock);
        end
    endtask

    // The answer stands for one cycle only, so it is looked at on the
    // next falling edge; an idle cycle then separates calls.
    task rd_check(input [7:0] a, input [7:0] exp);
        begin
            rd_en = 1'b1; address = a;
            @(negedge clock) rd_en = 1'b0;
            check("read valid", {7'h00, rd_valid}, 8'h01);
            check($sformatf("reg %h", a), rd_data, exp);
            @(negedge clock);
        end
    endtask

    task wait_state(input [1:0] st, input integer lim);
        integer n;
        begin
            n = 0;
            while (state !== st && n < lim) begin
                @(negedge clock) n = n + 1;
            end
            if (state !== st) begin
                check("state wait", {6'h00, state}, {6'h00, st});
                end_of_test;
            end
        end
    endtask

    // Counts cycles from entering the diagnostic state to the measurement.
    task gap_check(input integer lo);
        integer n;
        begin
            n = 0;
            while (measure !== 1'b1 && n < 4000) begin
                @(negedge clock) n = n + 1;
            end
            check("ramp settle gap", {7'h00, n >= lo && n <= lo + 12}, 8'h01);
            if (n >= 4000) end_of_test;
        end
    endtask

    initial begin
        repeat (3) @(negedge clock);
        reset_n = 1'b1;
        rd_check(8'h03, 8'h04);
        rd_check(8'h04, 8'h55);
        rd_check(8'h05, 8'hcf);
        rd_check(8'h09, 8'h00);
        rd_check(8'h0a, 8'h11);
        rd_check(8'h0c, 8'h00);
        rd_check(8'h0e, 8'h00);
        rd_check(8'h0f, 8'h40);
        rd_check(8'h02, 8'h00);
        for (i = 0; i < 8; i = i + 1) begin
            v = {i[1:0], i[2:0], i[2:0]};
            wr(8'h03, v);
            check("rate", {6'h00, rate}, {6'h00, v[7:6]});
            check("slot", {5'h00, slot}, {5'h00, v[5:3]});
            check("format", {5'h00, fmt}, {5'h00, v[2:0]});
            check("invalid", {7'h00, invalid}, {7'h00, v[7:6] == 2'h3 || i == 7});
            rd_check(8'h03, v);
        end
        wr(8'h0c, 8'hff);
        rd_check(8'h0c, 8'h00);
        wr(8'h09, 8'h1d);
        rd_check(8'h09, 8'h1d);
        wr(8'h0a, 8'h9a);
        check("short limit", {4'h0, short_limit_sel}, 8'h09);
        wr(8'h04, 8'h2a);
        wait_state(2'h0, 20);
        wr(8'h05, 8'hd2);
        for (i = 1; i < 4; i = i + 1) begin
            frame_strobe = 1'b1;
            @(negedge clock) frame_strobe = 1'b0;
            repeat (3) @(negedge clock);
            check("level step", output_level, 8'hcf + i[7:0]);
        end
        check("muted", {7'h00, output_muted}, 8'h00);
        wr(8'h05, 8'h06);
        repeat (420) @(negedge clock) frame_strobe = ~frame_strobe;
        check("level low", output_level, 8'h06);
        check("muted low", {7'h00, output_muted}, 8'h01);
        // Rate code 01 moves the level one code every second strobe.
        wr(8'h01, 8'h04);
        wr(8'h05, 8'h07);
        for (i = 0; i < 2; i = i + 1) begin
            frame_strobe = 1'b1;
            @(negedge clock) frame_strobe = 1'b0;
            repeat (2) @(negedge clock);
            check("slow step", output_level, 8'h06 + i[7:0]);
        end
        check("muted at floor", {7'h00, output_muted}, 8'h00);
        wr(8'h04, 8'h55);
        wait_state(2'h1, 20);
        wr(8'h09, 8'h02);
        check("line-out on", {7'h00, lineout_check_on}, 8'h01);
        flags_set = 5'h11;
        wr(8'h04, 8'h00);
        wait_state(2'h3, 5);
        gap_check(1500);
        wait_state(2'h0, 40);
        rd_check(8'h0c, 8'h80);
        rd_check(8'h0e, 8'h08);
        wr(8'h04, 8'h55);
        wait_state(2'h1, 20);
        wr(8'h09, 8'h20);
        flags_set = 5'h06;
        reply_delay = 8'h28;
        wr(8'h04, 8'h80);
        wait_state(2'h3, 5);
        gap_check(2000);
        wait_state(2'h2, 100);
        rd_check(8'h0c, 8'h30);
        rd_check(8'h0e, 8'h00);
        channel_fault = 1'b1;
        @(negedge clock) channel_fault = 1'b0;
        wait_state(2'h3, 5);
        wait_state(2'h2, 2200);
        wr(8'h09, 8'h40);
        reply_delay = 8'hff;
        wr(8'h04, 8'hc0);
        wait_state(2'h3, 5);
        gap_check(2500);
        wr(8'h09, 8'hc0);
        repeat (3) @(negedge clock);
        check("abort", {7'h00, measure || state == 2'h3}, 8'h00);
        rd_check(8'h0c, 8'h00);
        wr(8'h04, 8'h55);
        // The host clears the cancel bit before any further run.
        wr(8'h09, 8'h00);
        wait_state(2'h1, 20);
        end_of_test;
    end
endmodule // aacd_regs_tb
